// File: shared/icu_pkg.sv
// Constants, carriers and register map of the interrupt request and acceptance controller
// Behaviour
// - Acceptance fetches winner number and level
// - Acceptance read clears the returned request bit
// - Software vector read also clears winner request
// - Reset loads stack pointer with zero
// - Non-maskable request can never be blocked
// - Polarity change may set request; software clears
// - Control write completes before enable re-arms
// - Request during control rewrite is not lost
// - Timer A0 control at index 55h, clearable
package icu_pkg;

   // Register indices; byte address is four times the index
   localparam int unsigned ICU_IDX_W = 8;
   localparam logic [7:0] ICU_IDX_VECTOR = 8'h00;
   localparam logic [7:0] ICU_IDX_STATUS = 8'h40;
   localparam logic [7:0] ICU_IDX_MASK = 8'h41;
   localparam logic [7:0] ICU_IDX_SP = 8'h42;
   localparam logic [7:0] ICU_IDX_CTRL_BASE = 8'h55;

   // Source layout: source 0 is timer A0, external pins follow
   localparam int unsigned ICU_EXT_FIRST = 1;
   localparam int unsigned ICU_EXT_PINS = 3;
   localparam int unsigned ICU_NUM_W = 6;
   localparam int unsigned ICU_LEVEL_W = 3;
   localparam int unsigned ICU_VEC_LEVEL_LSB = 8;

   // Status bit positions
   localparam int unsigned ICU_STAT_NMI = 0;
   localparam int unsigned ICU_STAT_ACCEPT = 1;
   localparam int unsigned ICU_STAT_SWREAD = 2;
   localparam int unsigned ICU_STAT_W = 3;

   // Reset values
   localparam logic [15:0] ICU_SP_RESET = 16'h0000;
   localparam logic [7:0] ICU_CTRL_RESET = 8'h00;
   localparam logic [2:0] ICU_STAT_RESET = 3'h0;
   localparam logic [2:0] ICU_MASK_RESET = 3'h0;

   // Per-source control register layout
   typedef struct packed {
      logic [2:0] rsv;
      logic pol;
      logic req;
      logic [2:0] level;
   } icu_ctrl_s;

   // Vector information handed to the core
   typedef struct packed {
      logic [5:0] num;
      logic [2:0] level;
   } icu_vec_s;

   // Read path of the bus slave
   typedef enum logic [1:0] {
      ICU_RD_IDLE = 2'b00,
      ICU_RD_WAIT = 2'b01,
      ICU_RD_OUT = 2'b11
   } icu_rd_e;

endpackage

// File: hw/icu_src_cell.sv
// One interrupt source: control register, pin edge detect and request bit
`timescale 1ns/100ps
`default_nettype none
module icu_src_cell
   import icu_pkg::*;
#(
   parameter bit IS_EXT = 1'b0
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ctrl_we,
   input wire icu_ctrl_s ctrl_wdata,
   input wire logic event_in,
   input wire logic pin_in,
   input wire logic accept_clr,
   output icu_ctrl_s ctrl_q
);

   logic pin_meta_r;
   logic pin_sync_r;
   logic pin_adj_prev_r;
   logic pin_adj;
   logic edge_hit;
   logic set_req;
   logic pol_r;
   logic req_r;
   logic [2:0] level_r;
   icu_ctrl_s ctrl_r;

   // Pin synchroniser, only the second stage is looked at
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pin_meta_r <= 1'b1;
         pin_sync_r <= 1'b1;
      end
      else
      begin
         pin_meta_r <= pin_in;
         pin_sync_r <= pin_meta_r;
      end
   end

   // Polarity 0 takes falling edges, 1 rising edges
   assign pin_adj = pin_sync_r ^ ~ctrl_r.pol;

   // Flipping polarity can look like an edge; software clears it after
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         pin_adj_prev_r <= 1'b0;
      else
         pin_adj_prev_r <= pin_adj;
   end

   assign edge_hit = IS_EXT && pin_adj && !pin_adj_prev_r;
   assign set_req = event_in || edge_hit;

   // Level and polarity fields
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pol_r <= ICU_CTRL_RESET[4];
         level_r <= ICU_CTRL_RESET[2:0];
      end
      else if (ctrl_we)
      begin
         pol_r <= IS_EXT ? ctrl_wdata.pol : 1'b0;
         level_r <= ctrl_wdata.level;
      end
   end

   // Request bit: a new event beats both a write and an acceptance
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         req_r <= ICU_CTRL_RESET[3];
      else if (set_req)
         req_r <= 1'b1;
      else if (ctrl_we)
         req_r <= ctrl_wdata.req;
      else if (accept_clr)
         req_r <= 1'b0;
   end

   // Reserved bits are not stored and always read as their reset value
   assign ctrl_r = {ICU_CTRL_RESET[7:5], pol_r, req_r, level_r};
   assign ctrl_q = ctrl_r;

endmodule
`default_nettype wire

// File: hw/icu_top.sv
// Interrupt request and acceptance controller with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module icu_top
   import icu_pkg::*;
#(
   parameter int unsigned NUM_SRC = 8
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ext_request_pin_zero,
   input wire logic ext_request_pin_one,
   input wire logic ext_request_pin_two,
   input wire logic nmi_pin_n,
   input wire logic [NUM_SRC-1:0] src_event,
   input wire logic int_enable,
   input wire logic [2:0] core_ipl,
   input wire logic core_accept,
   output logic irq_req,
   output icu_vec_s vec_info,
   output logic vec_valid,
   output logic nmi_req,
   input wire logic nmi_accept,
   output logic [15:0] stack_ptr,
   output logic irq
);

   logic xfer;
   icu_rd_e rd_state_r;
   logic [ICU_IDX_W-1:0] rd_idx_r;
   logic [31:0] hrdata_r;
   logic [31:0] rd_value;
   logic wr_pend_r;
   logic [ICU_IDX_W-1:0] wr_idx_r;
   logic sw_vec_clr;
   logic vec_clr;
   logic win_valid;
   logic [ICU_NUM_W-1:0] win_num;
   logic [ICU_LEVEL_W-1:0] win_level;
   icu_ctrl_s ctrl_q [NUM_SRC];
   logic [NUM_SRC-1:0] ctrl_we;
   logic [NUM_SRC-1:0] pin_vec;
   logic [NUM_SRC-1:0] accept_clr;
   icu_vec_s vec_info_r;
   logic vec_valid_r;
   logic nmi_meta_r;
   logic nmi_sync_r;
   logic nmi_prev_r;
   logic nmi_fall;
   logic nmi_req_r;
   logic [ICU_STAT_W-1:0] status_r;
   logic [ICU_STAT_W-1:0] mask_r;
   logic [ICU_STAT_W-1:0] stat_set;
   logic [ICU_STAT_W-1:0] stat_w1c;
   logic [15:0] sp_r;

   // Bus handshake: reads take one wait state, writes none
   assign xfer = hsel && htrans[1] && hready;
   assign hreadyout = (rd_state_r != ICU_RD_WAIT);
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   // Read path; the wait state lets a write in its data phase land first
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         rd_state_r <= ICU_RD_IDLE;
         rd_idx_r <= '0;
         hrdata_r <= 32'h0000_0000;
      end
      else
      begin
         case (rd_state_r)
            ICU_RD_WAIT:
            begin
               hrdata_r <= rd_value;
               rd_state_r <= ICU_RD_OUT;
            end
            ICU_RD_IDLE, ICU_RD_OUT:
            begin
               if (xfer && !hwrite)
               begin
                  rd_idx_r <= haddr[ICU_IDX_W+1:2];
                  rd_state_r <= ICU_RD_WAIT;
               end
               else
                  rd_state_r <= ICU_RD_IDLE;
            end
            default:
               rd_state_r <= ICU_RD_IDLE;
         endcase
      end
   end

   // Write address phase capture
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         wr_pend_r <= 1'b0;
         wr_idx_r <= '0;
      end
      else
      begin
         wr_pend_r <= xfer && hwrite;
         if (xfer && hwrite)
            wr_idx_r <= haddr[ICU_IDX_W+1:2];
      end
   end

   // Highest nonzero level wins, lowest index on a tie
   always_comb
   begin
      win_valid = 1'b0;
      win_num = '0;
      win_level = '0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         if (ctrl_q[i].req && ctrl_q[i].level > win_level)
         begin
            win_valid = 1'b1;
            win_level = ctrl_q[i].level;
            win_num = ICU_NUM_W'(i);
         end
      end
   end

   // Maskable request to the core, gated by enable flag and level
   assign irq_req = int_enable && win_valid && (win_level > core_ipl);

   // A vector read by software has the same clearing effect as acceptance
   assign sw_vec_clr = (rd_state_r == ICU_RD_WAIT) && (rd_idx_r == ICU_IDX_VECTOR);
   assign vec_clr = (core_accept || sw_vec_clr) && win_valid;

   // External pins sit on fixed sources; others see an idle high pin
   always_comb
   begin
      pin_vec = '1;
      pin_vec[ICU_EXT_FIRST +: ICU_EXT_PINS] = {ext_request_pin_two, ext_request_pin_one,
         ext_request_pin_zero};
   end

   // One cell per source; timer A0 at the base index
   for (genvar g = 0; g < NUM_SRC; g++)
   begin : g_src
      assign ctrl_we[g] = wr_pend_r && (wr_idx_r == ICU_IDX_CTRL_BASE + 8'(g));
      assign accept_clr[g] = vec_clr && (win_num == ICU_NUM_W'(g));
      icu_src_cell #(
         .IS_EXT((g >= ICU_EXT_FIRST) && (g < ICU_EXT_FIRST + ICU_EXT_PINS))
      ) u_cell (
         .sys_clk(sys_clk),
         .rst_n(rst_n),
         .ctrl_we(ctrl_we[g]),
         .ctrl_wdata(icu_ctrl_s'(hwdata[7:0])),
         .event_in(src_event[g]),
         .pin_in(pin_vec[g]),
         .accept_clr(accept_clr[g]),
         .ctrl_q(ctrl_q[g])
      );
   end

   // Vector information latched on core acceptance
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         vec_info_r <= '0;
         vec_valid_r <= 1'b0;
      end
      else
      begin
         vec_valid_r <= core_accept && win_valid;
         if (core_accept && win_valid)
         begin
            vec_info_r.num <= win_num;
            vec_info_r.level <= win_level;
         end
      end
   end

   assign vec_info = vec_info_r;
   assign vec_valid = vec_valid_r;

   // NMI pin synchroniser, idle high
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         nmi_meta_r <= 1'b1;
         nmi_sync_r <= 1'b1;
         nmi_prev_r <= 1'b1;
      end
      else
      begin
         nmi_meta_r <= nmi_pin_n;
         nmi_sync_r <= nmi_meta_r;
         nmi_prev_r <= nmi_sync_r;
      end
   end

   assign nmi_fall = nmi_prev_r && !nmi_sync_r;

   // NMI pending: no enable, mask or level can hold it back
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         nmi_req_r <= 1'b0;
      else if (nmi_fall)
         nmi_req_r <= 1'b1;
      else if (nmi_accept)
         nmi_req_r <= 1'b0;
   end

   assign nmi_req = nmi_req_r;

   // Sticky status, write one to clear; a new event wins over the clear
   assign stat_set = {sw_vec_clr && win_valid, core_accept && win_valid, nmi_fall};
   assign stat_w1c = (wr_pend_r && wr_idx_r == ICU_IDX_STATUS) ? hwdata[ICU_STAT_W-1:0] : '0;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         status_r <= ICU_STAT_RESET;
      else
         status_r <= (status_r & ~stat_w1c) | stat_set;
   end

   // Mask and stack pointer registers
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         mask_r <= ICU_MASK_RESET;
         sp_r <= ICU_SP_RESET;
      end
      else if (wr_pend_r)
      begin
         if (wr_idx_r == ICU_IDX_MASK)
            mask_r <= hwdata[ICU_STAT_W-1:0];
         if (wr_idx_r == ICU_IDX_SP)
            sp_r <= hwdata[15:0];
      end
   end

   assign stack_ptr = sp_r;
   assign irq = |(status_r & mask_r);

   // Read data mux; unmapped indices read as zero
   always_comb
   begin
      rd_value = 32'h0000_0000;
      case (rd_idx_r)
         ICU_IDX_VECTOR:
         begin
            rd_value[ICU_NUM_W-1:0] = win_num;
            rd_value[ICU_VEC_LEVEL_LSB +: ICU_LEVEL_W] = win_level;
         end
         ICU_IDX_STATUS:
            rd_value[ICU_STAT_W-1:0] = status_r;
         ICU_IDX_MASK:
            rd_value[ICU_STAT_W-1:0] = mask_r;
         ICU_IDX_SP:
            rd_value[15:0] = sp_r;
         default:
         begin
            for (int i = 0; i < NUM_SRC; i++)
            begin
               if (rd_idx_r == ICU_IDX_CTRL_BASE + 8'(i))
                  rd_value[7:0] = ctrl_q[i];
            end
         end
      endcase
   end

endmodule
`default_nettype wire

// File: sim/icu_core_model.sv
// Core model that takes maskable and non-maskable requests
`timescale 1ns/100ps
`default_nettype none
module icu_core_model
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic irq_req,
   input wire logic nmi_req,
   output logic core_accept,
   output logic nmi_accept
);
   // One acceptance at a time; go low stalls maskable acceptance only, NMI acceptance goes on
   always_ff @(posedge sys_clk)
   begin
      core_accept <= rst_n & go & irq_req & ~core_accept;
      nmi_accept <= rst_n & nmi_req & ~nmi_accept;
   end
endmodule
`default_nettype wire

// File: sim/icu_top_chk.sv
// Checker of bus timing, acceptance and non-maskable request at the ports
`timescale 1ns/100ps
`default_nettype none
module icu_top_chk
   import icu_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic int_enable,
   input wire logic core_accept,
   input wire logic irq_req,
   input wire logic vec_valid,
   input wire logic nmi_req,
   input wire logic nmi_accept,
   input wire logic [15:0] stack_ptr
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Transfer taken, and the one wait cycle of a read
   sequence taken_s(w); hsel && htrans[1] && hready && hwrite == w; endsequence
   sequence rd_phase_s; !hreadyout ##1 hreadyout; endsequence
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   chk_write_nowait: assert property (taken_s(1'b1) |=> hreadyout)
      else $error("write data phase stalled");
   chk_read_wait: assert property (taken_s(1'b0) |=> rd_phase_s)
      else $error("read data phase timing wrong");
   chk_irq_gate: assert property (irq_req |-> int_enable)
      else $error("request shown while flag clear");
   chk_vec_cause: assert property (vec_valid |-> $past(core_accept))
      else $error("vector without acceptance");
   chk_accept_vec: assert property (core_accept && irq_req |=> vec_valid)
      else $error("acceptance gave no vector");
   chk_nmi_sticky: assert property (nmi_req && !nmi_accept |=> nmi_req)
      else $error("nmi request dropped unaccepted");
   chk_sp_reset: assert property ($rose(rst_n) |-> stack_ptr == ICU_SP_RESET)
      else $error("stack pointer not zero after reset");
endmodule
bind icu_top icu_top_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .int_enable(int_enable), .core_accept(core_accept), .irq_req(irq_req),
   .vec_valid(vec_valid), .nmi_req(nmi_req), .nmi_accept(nmi_accept),
   .stack_ptr(stack_ptr));
`default_nettype wire

// File: sim/icu_top_tb.sv
// Self-checking bench of the interrupt controller over its register bus
`timescale 1ns/100ps
`default_nettype none
module icu_top_tb;
   import icu_pkg::*;
   localparam logic [7:0] C0 = ICU_IDX_CTRL_BASE;
   logic sys_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, go;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize, core_ipl;
   logic p0, p1, p2, nmi_n, int_en, c_acc, n_acc, irq_req, vec_valid, nmi_req, irq;
   logic [7:0] src_event;
   logic [15:0] stack_ptr;
   icu_vec_s vec_info;
   int n_errors, check_count;
   icu_top #(.NUM_SRC(8)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_request_pin_zero(p0),
      .ext_request_pin_one(p1), .ext_request_pin_two(p2), .nmi_pin_n(nmi_n),
      .src_event(src_event), .int_enable(int_en), .core_ipl(core_ipl), .core_accept(c_acc),
      .irq_req(irq_req), .vec_info(vec_info), .vec_valid(vec_valid), .nmi_req(nmi_req),
      .nmi_accept(n_acc), .stack_ptr(stack_ptr), .irq(irq));
   icu_core_model core (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .irq_req(irq_req),
      .nmi_req(nmi_req), .core_accept(c_acc), .nmi_accept(n_acc));
   assign hready = hreadyout;
   // 50 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // Hang guard; the tests need well under a thousand cycles
   initial
   begin
      #100us;
      n_errors++;
      results();
   end
   task automatic results;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic tend(input string s);
      $display("test %s complete", s);
   endtask
   // Single transfer; ready and read data are taken at the rising edge
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'b00};
      do @(posedge sys_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge sys_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, idx, d, x);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, idx, 32'h0, x);
      chk(x, exp);
   endtask
   task automatic ev(input int g);
      src_event[g] <= 1'b1;
      @(posedge sys_clk);
      src_event <= 8'h00;
      @(posedge sys_clk);
   endtask
   // Level outputs are looked at mid-cycle, then back on the edge
   task automatic probe(input logic [1:0] k, input logic e);
      @(negedge sys_clk);
      chk(k == 2'd0 ? irq : k == 2'd1 ? irq_req : nmi_req, e);
      @(posedge sys_clk);
   endtask
   task automatic wvec(input logic [8:0] exp);
      int n;
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (vec_valid !== 1'b1 && n < 20);
      chk(vec_valid, 1'b1);
      chk(vec_info, exp);
      @(posedge sys_clk);
   endtask
   // Main sequence
   initial
   begin
      n_errors = 0;
      check_count = 0;
      rst_n = 1'b0;
      go = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      {p0, p1, p2, nmi_n} = 4'hf;
      int_en = 1'b0;
      core_ipl = 3'h0;
      src_event = 8'h00;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      chk(stack_ptr, 32'h0);
      rdc(ICU_IDX_SP, 32'h0);
      wr(ICU_IDX_SP, 32'h0400);
      rdc(ICU_IDX_SP, 32'h0400);
      wr(8'h30, 32'hff);
      rdc(8'h30, 32'h0);
      wr(C0, 32'h0d);
      rdc(C0, 32'h0d);
      wr(C0, 32'h00);
      rdc(C0, 32'h00);
      tend("registers");
      // Flag clear while programming; no request in the first cycles
      // An event landing with the control write must survive it
      fork
         wr(C0, 32'h03);
         begin
            @(posedge sys_clk);
            src_event[0] <= 1'b1;
            @(posedge sys_clk);
            src_event <= 8'h00;
         end
      join
      rdc(C0, 32'h0b);
      wr(C0 + 8'h2, 32'h06);
      ev(0);
      ev(2);
      probe(2'd1, 1'b0);
      core_ipl <= 3'h6;
      int_en <= 1'b1;
      probe(2'd1, 1'b0);
      core_ipl <= 3'h0;
      int_en <= 1'b0;
      repeat (2) @(posedge sys_clk);
      int_en <= 1'b1;
      go <= 1'b1;
      wvec({6'd2, 3'd6});
      wvec({6'd0, 3'd3});
      go <= 1'b0;
      int_en <= 1'b0;
      rdc(C0 + 8'h2, 32'h06);
      rdc(C0, 32'h03);
      rdc(ICU_IDX_STATUS, 32'h2);
      wr(ICU_IDX_STATUS, 32'h2);
      rdc(ICU_IDX_STATUS, 32'h0);
      tend("acceptance");
      // Deliberate software read of the vector word, then the interrupt line
      wr(C0 + 8'h1, 32'h04);
      ev(1);
      rdc(ICU_IDX_VECTOR, 32'h0401);
      rdc(C0 + 8'h1, 32'h04);
      wr(ICU_IDX_MASK, 32'h4);
      probe(2'd0, 1'b1);
      wr(ICU_IDX_MASK, 32'h0);
      probe(2'd0, 1'b0);
      wr(ICU_IDX_MASK, 32'h4);
      wr(ICU_IDX_STATUS, 32'h4);
      probe(2'd0, 1'b0);
      rdc(ICU_IDX_STATUS, 32'h0);
      tend("vector read");
      // Pin edges under both polarities
      p0 <= 1'b0;
      repeat (5) @(posedge sys_clk);
      rdc(C0 + 8'h1, 32'h0c);
      wr(C0 + 8'h1, 32'h14);
      wr(C0 + 8'h1, 32'h14);
      rdc(C0 + 8'h1, 32'h14);
      p0 <= 1'b1;
      repeat (5) @(posedge sys_clk);
      rdc(C0 + 8'h1, 32'h1c);
      wr(C0 + 8'h1, 32'h00);
      tend("pins");
      // Non-maskable request with flag clear and mask holding only the software vector read bit (4)
      nmi_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      probe(2'd2, 1'b1);
      repeat (4) @(posedge sys_clk);
      rdc(ICU_IDX_STATUS, 32'h1);
      probe(2'd2, 1'b0);
      nmi_n <= 1'b1;
      tend("nmi");
      // Mid-run reset must bring the programmed stack pointer back to zero
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rdc(ICU_IDX_SP, 32'h0);
      tend("reset");
      results();
   end
endmodule
`default_nettype wire
